// [design/sic_pkg.sv]
// constants for the stack pointer and interrupt entry/return control
// assumes an 8-bit i/o register port driven by the instruction sequencer
package sic_pkg;
	localparam logic [5:0] SIC_STACK_POINTER_LOW_ADDR  = 6'h3D;
	localparam logic [5:0] SIC_STACK_POINTER_HIGH_ADDR = 6'h3E;
	localparam logic [5:0] SIC_STATUS_FLAGS_ADDR       = 6'h3F;
	localparam logic [7:0] SIC_STACK_POINTER_RST       = 8'h00;
	localparam logic [7:0] SIC_STATUS_FLAGS_RST        = 8'h00;
	localparam int         SIC_GIE_BIT                 = 7;
	localparam int         SIC_ENTRY_CYCLES            = 4;
	localparam int         SIC_SLEEP_EXTRA_CYCLES      = 4;
	localparam int         SIC_RETURN_CYCLES           = 4;
	localparam logic [3:0] SIC_ENTRY_CNT = 4'(SIC_ENTRY_CYCLES - 1);
	localparam logic [3:0] SIC_SLEEP_CNT = 4'(SIC_ENTRY_CYCLES + SIC_SLEEP_EXTRA_CYCLES - 1);
	localparam logic [3:0] SIC_RETURN_CNT = 4'(SIC_RETURN_CYCLES - 1);
	typedef enum logic [1:0] {
		SIC_RUN    = 2'b00,
		SIC_ENTRY  = 2'b01,
		SIC_RETURN = 2'b11,
		SIC_ONE    = 2'b10
	} sic_state_type;
endpackage : sic_pkg

// [design/sic_prio_enc.sv]
// priority picker: lowest set index wins
// assumes requests already gated by their enables
`default_nettype none
module sic_prio_enc #(
	parameter int N = 8,
	parameter int W = 3
) (
	// requests
	input  wire logic [N-1:0] req,
	// result
	output logic              any,
	output logic [W-1:0]      idx
);
	always_comb begin
		any = 1'b0;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				any = 1'b1;
				idx = W'(i);
			end
		end
	end
endmodule : sic_prio_enc
`default_nettype wire

// [design/sic_core.sv]
// stack pointer registers, global enable, interrupt flags and entry/return sequencing
// assumes single-cycle instruction strobes from the sequencer, all synchronous to sys_clk
`default_nettype none
// Operation
// - stack grows downward; pointer always addresses the stack top.
// - byte push lowers the pointer by one.
// - call or interrupt entry lowers the pointer by two.
// - byte pop raises the pointer by one.
// - subroutine or interrupt return raises the pointer by two.
// - pointer is two rw byte registers at 0x3E high, 0x3D low, reset zero.
// - logic runs straight on the undivided core clock; here every register updates only while clk_en is high.
// - register-operand alu result written back within one cycle.
// - source taken only when its enable and global enable are set.
// - lower vector index has higher priority; reset highest.
// - accepting an interrupt clears the global enable.
// - global enable set inside a handler allows nested interrupts.
// - interrupt return sets the global enable.
// - event flag cleared by hardware when its vector is taken.
// - writing one to a flag clears it; zero leaves it.
// - events while disabled set and hold flags until served or cleared.
// - condition sources request only while the condition persists.
// - after interrupt return one instruction runs before another entry.
// - status flags register is neither saved nor restored automatically.
// - global disable blocks any interrupt, even one in the same cycle.
// - after global enable the next instruction runs before any entry.
// - entry takes at least four cycles, pushing the program counter.
// - entry from sleep takes four more cycles.
// - return takes four cycles, pops pc, pointer up two, enable set.
module sic_core
	import sic_pkg::*;
#(
	parameter int N_SRC = 8,
	parameter int IDX_W = 3
) (
	// clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rstn,
	input  wire logic                clk_en,
	// i/o register port
	input  wire logic [5:0]          io_addr,
	input  wire logic                io_wr,
	input  wire logic [7:0]          io_wdata,
	output logic      [7:0]          io_rdata,
	// instruction strobes from the sequencer
	input  wire logic                push_byte,
	input  wire logic                pop_byte,
	input  wire logic                call_push,
	input  wire logic                sub_return,
	input  wire logic                int_return,
	input  wire logic                set_gie,
	input  wire logic                clr_gie,
	input  wire logic                instr_done,
	input  wire logic                sleeping,
	// interrupt sources
	input  wire logic [N_SRC-1:0]    src_enable,
	input  wire logic [N_SRC-1:0]    src_is_level,
	input  wire logic [N_SRC-1:0]    src_event,
	input  wire logic [N_SRC-1:0]    src_level,
	input  wire logic [N_SRC-1:0]    flag_clear,
	// outputs
	output logic      [15:0]         stack_pointer,
	output logic                     global_enable,
	output logic      [N_SRC-1:0]    flags,
	output logic                     entry_busy,
	output logic                     return_busy,
	output logic                     vector_valid,
	output logic      [IDX_W-1:0]    vector_idx
);
	logic [7:0]       sp_low_r, sp_low_nxt;
	logic [7:0]       sp_high_r, sp_high_nxt;
	logic             gie_r, gie_nxt;
	logic [N_SRC-1:0] flag_r, flag_nxt;
	sic_state_type    state_r, state_nxt;
	logic [3:0]       cnt_r, cnt_nxt;
	logic             hold_r, hold_nxt;
	logic [IDX_W-1:0] vec_r, vec_nxt;
	logic             vld_r, vld_nxt;
	logic [7:0]       rdata_r, rdata_nxt;

	wire [15:0]       sp_cur = {sp_high_r, sp_low_r};
	wire              wr_low  = io_wr && (io_addr == SIC_STACK_POINTER_LOW_ADDR);
	wire              wr_high = io_wr && (io_addr == SIC_STACK_POINTER_HIGH_ADDR);
	wire              wr_stat = io_wr && (io_addr == SIC_STATUS_FLAGS_ADDR);
	// flags of level sources are still stored but ignored; level line requests directly
	wire [N_SRC-1:0]  pend = (flag_r & ~src_is_level) | (src_level & src_is_level);
	wire [N_SRC-1:0]  req  = pend & src_enable;
	wire              any_req;
	wire [IDX_W-1:0]  pick;
	// clr_gie gates immediately; set_gie and recent return hold off one instruction
	wire              may_take = gie_r && !clr_gie && !hold_r && instr_done
	                             && (state_r == SIC_RUN);
	wire              take = may_take && any_req;
	wire [N_SRC-1:0]  take_mask = take ? (N_SRC'(1) << pick) : '0;

	sic_prio_enc #(.N(N_SRC), .W(IDX_W)) u_prio (
		.req (req),
		.any (any_req),
		.idx (pick)
	);

	always_comb begin
		logic [15:0] sp_t;
		sp_t        = sp_cur;
		state_nxt   = state_r;
		cnt_nxt     = cnt_r;
		hold_nxt    = hold_r;
		gie_nxt     = gie_r;
		vec_nxt     = vec_r;
		vld_nxt     = 1'b0;
		// stack pointer moves, downward growth
		if (push_byte)  sp_t = sp_cur - 16'h0001;
		if (pop_byte)   sp_t = sp_cur + 16'h0001;
		if (call_push)  sp_t = sp_cur - 16'h0002;
		if (sub_return) sp_t = sp_cur + 16'h0002;
		sp_low_nxt  = wr_low  ? io_wdata : sp_t[7:0];
		sp_high_nxt = wr_high ? io_wdata : sp_t[15:8];
		if (instr_done) hold_nxt = 1'b0;
		if (set_gie) begin
			gie_nxt  = 1'b1;
			hold_nxt = 1'b1;
		end
		if (clr_gie) gie_nxt = 1'b0;
		// status write carries only the global enable here; other flags live elsewhere
		if (wr_stat) gie_nxt = io_wdata[SIC_GIE_BIT];
		case (state_r)
			SIC_RUN: begin
				if (take) begin
					state_nxt = SIC_ENTRY;
					cnt_nxt   = sleeping ? SIC_SLEEP_CNT : SIC_ENTRY_CNT;
					gie_nxt   = 1'b0;
					vec_nxt   = pick;
					{sp_high_nxt, sp_low_nxt} = sp_cur - 16'h0002;
				end else if (int_return) begin
					state_nxt = SIC_RETURN;
					cnt_nxt   = SIC_RETURN_CNT;
				end
			end
			SIC_ENTRY: begin
				if (cnt_r == 4'h0) begin
					state_nxt = SIC_RUN;
					vld_nxt   = 1'b1;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			SIC_RETURN: begin
				if (cnt_r == 4'h0) begin
					state_nxt = SIC_ONE;
					gie_nxt   = 1'b1;
					hold_nxt  = 1'b1;
					{sp_high_nxt, sp_low_nxt} = sp_cur + 16'h0002;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			SIC_ONE: state_nxt = SIC_RUN;
			default: state_nxt = SIC_RUN;
		endcase
		// set beats clear; taking the vector clears an event flag
		flag_nxt = (flag_r & ~(flag_clear | take_mask)) | src_event;
		case (io_addr)
			SIC_STACK_POINTER_LOW_ADDR:  rdata_nxt = sp_low_nxt;
			SIC_STACK_POINTER_HIGH_ADDR: rdata_nxt = sp_high_nxt;
			SIC_STATUS_FLAGS_ADDR:       rdata_nxt = {gie_nxt, 7'h00};
			default:                     rdata_nxt = 8'h00;
		endcase
	end

	// one clock drives every register, each updating only while clk_en is high
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sp_low_r  <= SIC_STACK_POINTER_RST;
			sp_high_r <= SIC_STACK_POINTER_RST;
			gie_r     <= SIC_STATUS_FLAGS_RST[SIC_GIE_BIT];
			flag_r    <= '0;
			state_r   <= SIC_RUN;
			cnt_r     <= 4'h0;
			hold_r    <= 1'b0;
			vec_r     <= '0;
			vld_r     <= 1'b0;
			rdata_r   <= 8'h00;
		end else if (clk_en) begin
			sp_low_r  <= sp_low_nxt;
			sp_high_r <= sp_high_nxt;
			gie_r     <= gie_nxt;
			flag_r    <= flag_nxt;
			state_r   <= state_nxt;
			cnt_r     <= cnt_nxt;
			hold_r    <= hold_nxt;
			vec_r     <= vec_nxt;
			vld_r     <= vld_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	logic [15:0] sp_out_r;
	logic        gie_out_r, ebusy_r, rbusy_r;
	logic [N_SRC-1:0] flags_out_r;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sp_out_r    <= 16'h0000;
			gie_out_r   <= 1'b0;
			flags_out_r <= '0;
			ebusy_r     <= 1'b0;
			rbusy_r     <= 1'b0;
		end else if (clk_en) begin
			sp_out_r    <= {sp_high_nxt, sp_low_nxt};
			gie_out_r   <= gie_nxt;
			flags_out_r <= flag_nxt;
			ebusy_r     <= (state_nxt == SIC_ENTRY);
			rbusy_r     <= (state_nxt == SIC_RETURN);
		end
	end

	assign stack_pointer = sp_out_r;
	assign global_enable = gie_out_r;
	assign flags         = flags_out_r;
	assign entry_busy    = ebusy_r;
	assign return_busy   = rbusy_r;
	assign vector_valid  = vld_r;
	assign vector_idx    = vec_r;
	assign io_rdata      = rdata_r;
endmodule : sic_core
`default_nettype wire

// [sim/sic_core_monitor.sv]
// assertions on the ports of the stack and interrupt control core
// assumes one clock domain; bound to every sic_core instance
`default_nettype none
module sic_core_monitor #(
	parameter int N_SRC = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// requests
	input wire logic clk_en,
	input wire logic io_wr,
	input wire logic push_byte,
	input wire logic pop_byte,
	input wire logic call_push,
	input wire logic sub_return,
	input wire logic int_return,
	input wire logic clr_gie,
	input wire logic sleeping,
	input wire logic [N_SRC-1:0] src_event,
	input wire logic [N_SRC-1:0] flag_clear,
	// results
	input wire logic [15:0] stack_pointer,
	input wire logic global_enable,
	input wire logic [N_SRC-1:0] flags,
	input wire logic entry_busy,
	input wire logic return_busy,
	input wire logic vector_valid
);
	wire logic idle = clk_en & ~io_wr & ~entry_busy & ~return_busy;
	wire logic [N_SRC-1:0] clr_only = flag_clear & ~src_event;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	push_dec_a: assert property (push_byte & ~pop_byte & ~call_push & ~sub_return & idle
		|=> entry_busy | stack_pointer == $past(stack_pointer) - 16'h1) else $error("push step");
	pop_inc_a: assert property (pop_byte & ~call_push & ~sub_return & idle
		|=> entry_busy | stack_pointer == $past(stack_pointer) + 16'h1) else $error("pop step");
	entry_sp_a: assert property ($rose(entry_busy) |-> !global_enable
		&& stack_pointer == $past(stack_pointer) - 16'h2) else $error("entry state");
	vec_time_a: assert property ($rose(entry_busy) && !$past(sleeping)
		|-> ##4 vector_valid) else $error("vector timing");
	sleep_time_a: assert property ($rose(entry_busy) && $past(sleeping) |-> ##8 vector_valid)
		else $error("sleep vector timing");
	ret_seq_a: assert property (int_return & idle |=> return_busy[*4]
		##1 (global_enable && stack_pointer == $past(stack_pointer, 5) + 16'h2)) else $error("return");
	clr_now_a: assert property (clr_gie & idle |=> !global_enable && !entry_busy)
		else $error("disable late");
	gate_off_a: assert property (!global_enable & idle |=> !entry_busy)
		else $error("entry while disabled");
	w1c_a: assert property (clk_en && clr_only != '0 |=> (flags & $past(clr_only)) == '0)
		else $error("flag kept");
	cover property ($rose(entry_busy));
	cover property ($fell(return_busy));
	cover property (vector_valid);
endmodule : sic_core_monitor
bind sic_core sic_core_monitor #(.N_SRC(N_SRC)) u_mon (.*);
`default_nettype wire

// [sim/sic_src_model.sv]
// event-type interrupt sources: each request is copied to its event on the next rising clock edge
// assumes requests change just after a falling edge
`default_nettype none
module sic_src_model (
	// clock and requests
	input wire logic clk,
	input wire logic [7:0] fire,
	// events to the core
	output logic [7:0] ev
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge clk) ev <= fire;
endmodule : sic_src_model
`default_nettype wire

// [sim/stack_and_interrupt_control_tb_top.sv]
// self-checking bench for the stack and interrupt control core
// assumes package, core, source model and monitor compiled first
`default_nettype none
module stack_and_interrupt_control_tb_top
	import sic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, io_wr = 1'b0, instr_done = 1'b1;
	logic push_byte = 1'b0, pop_byte = 1'b0, call_push = 1'b0, sub_return = 1'b0;
	logic int_return = 1'b0, set_gie = 1'b0, clr_gie = 1'b0, sleeping = 1'b0, look_r = 1'b0;
	logic global_enable, entry_busy, return_busy, vector_valid;
	logic [5:0] io_addr = 6'h00;
	logic [7:0] io_wdata = 8'h00, src_enable = 8'h00, src_is_level = 8'h00, fire = 8'h00;
	logic [7:0] src_level = 8'h00, flag_clear = 8'h00, io_rdata, src_event, flags;
	logic [15:0] stack_pointer, sp, q[$];
	logic [2:0] vector_idx, qv[$];
	logic [1:0] sel = 2'h0;
	logic [31:0] seed = 32'h0001216F;
	int n_mismatch = 0, checks = 0, cyc = 0;
	string nm[3] = '{"io_rdata", "flags", "stack_pointer"};
	always #4 sys_clk = ~sys_clk;
	sic_src_model u_src (.clk(sys_clk), .fire(fire), .ev(src_event));
	sic_core dut (.*);
	task automatic chk(input logic [15:0] e, input logic [15:0] s, input string n);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	endfunction : xs
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge sys_clk);
		s = 1'b0;
	endtask : pulse
	task automatic vpulse(ref logic [7:0] v, input logic [7:0] x);
		v = x;
		@(negedge sys_clk);
		v = 8'h00;
	endtask : vpulse
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		io_addr = a;
		io_wdata = d;
		pulse(io_wr);
		@(negedge sys_clk);
	endtask : wr
	// note an expected value; the watcher compares it one edge later
	task automatic look(input logic [1:0] s, input logic [5:0] a, input logic [15:0] e);
		sel = s;
		io_addr = a;
		q.push_back(e);
		look_r = 1'b1;
		@(negedge sys_clk);
		look_r = 1'b0;
		@(negedge sys_clk);
	endtask : look
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 1000) begin
			n_mismatch++;
			summarize();
		end
		if (vector_valid === 1'b1)
			chk(qv.size() > 0 ? 16'(qv.pop_front()) : 16'hFFFF, 16'(vector_idx), "vector_idx");
		if (look_r) begin
			#1;
			chk(q.pop_front(), sel == 2'h0 ? 16'(io_rdata) : sel == 2'h1 ? 16'(flags) : stack_pointer,
				nm[sel]);
		end
	end
	initial begin
		repeat (10) @(negedge sys_clk);
		rstn = 1'b1;
		@(negedge sys_clk);
		look(2'h0, SIC_STACK_POINTER_HIGH_ADDR, 16'h0000);
		look(2'h0, 6'h3C, 16'h0000);
		seed = xs(seed);
		sp = {4'h1, seed[11:0]};
		wr(SIC_STACK_POINTER_HIGH_ADDR, sp[15:8]);
		wr(SIC_STACK_POINTER_LOW_ADDR, sp[7:0]);
		look(2'h0, SIC_STACK_POINTER_LOW_ADDR, {8'h00, sp[7:0]});
		pulse(push_byte);
		pulse(call_push);
		look(2'h2, 6'h00, sp - 16'h0003);
		pulse(pop_byte);
		pulse(sub_return);
		look(2'h2, 6'h00, sp);
		clk_en = 1'b0;
		pulse(push_byte);
		clk_en = 1'b1;
		look(2'h2, 6'h00, sp);
		src_enable = 8'h05;
		vpulse(fire, 8'h24);
		look(2'h1, 6'h00, 16'h0024);
		vpulse(flag_clear, 8'h20);
		look(2'h1, 6'h00, 16'h0004);
		vpulse(fire, 8'h21);
		qv.push_back(3'h0);
		pulse(set_gie);
		repeat (8) @(negedge sys_clk);
		look(2'h1, 6'h00, 16'h0024);
		look(2'h2, 6'h00, sp - 16'h0002);
		look(2'h0, SIC_STATUS_FLAGS_ADDR, 16'h0000);
		qv.push_back(3'h2);
		pulse(int_return);
		repeat (14) @(negedge sys_clk);
		pulse(int_return);
		repeat (6) @(negedge sys_clk);
		look(2'h2, 6'h00, sp);
		look(2'h0, SIC_STATUS_FLAGS_ADDR, 16'h0080);
		clr_gie = 1'b1;
		src_enable = 8'h20;
		@(negedge sys_clk);
		clr_gie = 1'b0;
		look(2'h1, 6'h00, 16'h0020);
		vpulse(flag_clear, 8'h20);
		src_is_level = 8'h80;
		src_enable = 8'h80;
		vpulse(src_level, 8'h80);
		pulse(set_gie);
		repeat (8) @(negedge sys_clk);
		qv.push_back(3'h7);
		sleeping = 1'b1;
		src_level = 8'h80;
		repeat (12) @(negedge sys_clk);
		chk(16'h0000, 16'(qv.size()), "vector queue");
		summarize();
	end
endmodule : stack_and_interrupt_control_tb_top
`default_nettype wire
